// ===== inc/ofc_pkg.sv
// Notes on behaviour
// - Selected oscillator is measured against the divided system clock as time base.
// - Select 0 rc 32k, 1 rc 16M, 2 crystal 32k, 3 enhanced rc.
// - Writing one to start begins measurement when N is nonzero (zero N raises the zero-N irq instead); hardware clears it when done.
// - Count M is presented as 32 bits across high and low result registers.
// - M counts reference cycles during N selected oscillator cycles.
// - Reference tick is derived from system clock by a divider giving 16 MHz.
`default_nettype none
package ofc_pkg;
	localparam logic [7:0]  ADDR_REF_COUNT   = 8'h00;
	localparam logic [7:0]  ADDR_CTRL        = 8'h04;
	localparam logic [7:0]  ADDR_RESULT_LOW  = 8'h08;
	localparam logic [7:0]  ADDR_RESULT_HIGH = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h14;
	localparam int          CTRL_SEL_LSB     = 0;
	localparam int          CTRL_START_BIT   = 2;
	localparam int          CTRL_BUSY_BIT    = 3;
	localparam logic [1:0]  SEL_RC_32KHZ     = 2'h0;
	localparam logic [1:0]  SEL_RC_16MHZ     = 2'h1;
	localparam logic [1:0]  SEL_CRYSTAL_32K  = 2'h2;
	localparam logic [1:0]  SEL_ENHANCED_RC  = 2'h3;
	localparam int          SYS_CLK_HZ       = 50000000;
	localparam int          REF_CLK_HZ       = 16000000;
	// Fractional accumulator: add REF each cycle, tick on wrap past SYS
	localparam logic [25:0] REF_STEP         = 26'(REF_CLK_HZ);
	localparam logic [25:0] REF_WRAP         = 26'(SYS_CLK_HZ);
	localparam logic [31:0] RESET_REF_COUNT  = 32'h0000_0000;
	localparam logic [1:0]  RESET_SEL        = 2'h0;
	localparam logic [1:0]  RESET_IRQ_MASK   = 2'h0;
	localparam int          IRQ_DONE_BIT     = 0;
	localparam int          IRQ_ZERO_N_BIT   = 1;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_COUNT} ofc_state_e;

	typedef struct packed {
		logic [2:0] sync;
		logic       agreed;
		logic       prev;
	} ofc_sync_s;

	typedef struct packed {
		ofc_state_e  state;
		logic [25:0] acc;
		logic        tick;
		logic [31:0] ref_count;
		logic [1:0]  sel;
		logic [1:0]  meas_sel;
		logic [31:0] osc_left;
		logic [31:0] result;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic        awvalid_seen;
		logic        wvalid_seen;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ofc_state_s;
endpackage
`default_nettype wire

// ===== rtl/ofc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_edge_sync
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic osc_in,
	output logic      rise
);
	ofc_pkg::ofc_sync_s s_r;
	ofc_pkg::ofc_sync_s s_nxt;

	// Level counts only once the second and third stages agree
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[1:0], osc_in};
		if (s_r.sync[1] == s_r.sync[2])
			s_nxt.agreed = s_r.sync[2];
		s_nxt.prev = s_r.agreed;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign rise = s_r.agreed & ~s_r.prev;
endmodule
`default_nettype wire

// ===== rtl/ofc_calibrator.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_calibrator
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  osc_clk,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             irq
);
	ofc_pkg::ofc_state_s r;
	ofc_pkg::ofc_state_s r_nxt;
	logic [3:0]          osc_rise;
	logic                busy;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_sync
			// Each oscillator is brought into aclk before edges are counted
			ofc_edge_sync u_sync
			(
				.aclk    (aclk),
				.aresetn (aresetn),
				.osc_in  (osc_clk[g]),
				.rise    (osc_rise[g])
			);
		end
	endgenerate

	assign busy = (r.state != ofc_pkg::ST_IDLE);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				v[8*i +: 8] = d[8*i +: 8];
		return v;
	endfunction

	always_comb
	begin
		logic        wr_go;
		logic [31:0] w;
		logic [1:0]  set_ev;
		logic        sel_rise;
		r_nxt = r;
		set_ev = 2'h0;
		wr_go = 1'b0;
		w = 32'h0000_0000;
		sel_rise = osc_rise[r.meas_sel];
		// Divider: one-cycle tick at 16 MHz on average out of the 50 MHz clock
		if (r.acc + ofc_pkg::REF_STEP >= ofc_pkg::REF_WRAP)
		begin
			r_nxt.acc = 26'(r.acc + ofc_pkg::REF_STEP - ofc_pkg::REF_WRAP);
			r_nxt.tick = 1'b1;
		end
		else
		begin
			r_nxt.acc = 26'(r.acc + ofc_pkg::REF_STEP);
			r_nxt.tick = 1'b0;
		end
		case (r.state)
			ofc_pkg::ST_IDLE: ;
			// Wait for a first edge so counting spans whole oscillator periods
			ofc_pkg::ST_ARM:
			begin
				if (sel_rise)
					r_nxt.state = ofc_pkg::ST_COUNT;
			end
			ofc_pkg::ST_COUNT:
			begin
				if (r.tick)
					r_nxt.result = r.result + 32'h0000_0001;
				if (sel_rise)
				begin
					r_nxt.osc_left = r.osc_left - 32'h0000_0001;
					if (r.osc_left == 32'h0000_0001)
					begin
						r_nxt.state = ofc_pkg::ST_IDLE; // Start bit reads zero now
						set_ev[ofc_pkg::IRQ_DONE_BIT] = 1'b1;
					end
				end
			end
			default: r_nxt.state = ofc_pkg::ST_IDLE;
		endcase
		// AXI write: address and data taken in either order
		if (s_axi_awvalid && !r.awvalid_seen)
		begin
			r_nxt.awvalid_seen = 1'b1;
			r_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r.wvalid_seen)
		begin
			r_nxt.wvalid_seen = 1'b1;
			r_nxt.wdata = s_axi_wdata;
			r_nxt.wstrb = s_axi_wstrb;
		end
		if (r.awvalid_seen && r.wvalid_seen && !r.bvalid)
		begin
			wr_go = 1'b1;
			r_nxt.awvalid_seen = 1'b0;
			r_nxt.wvalid_seen = 1'b0;
			r_nxt.bvalid = 1'b1;
			r_nxt.bresp = ofc_pkg::RESP_OKAY;
			case (r.awaddr)
				ofc_pkg::ADDR_REF_COUNT:
				begin
					// N is frozen while a measurement runs
					if (!busy)
						r_nxt.ref_count = merge(r.ref_count, r.wdata, r.wstrb);
				end
				ofc_pkg::ADDR_CTRL:
				begin
					w = merge({28'h0, 1'b0, 1'b0, r.sel}, r.wdata, r.wstrb);
					if (!busy)
					begin
						r_nxt.sel = w[ofc_pkg::CTRL_SEL_LSB +: 2];
						if (w[ofc_pkg::CTRL_START_BIT])
						begin
							if (r.ref_count == 32'h0000_0000)
								set_ev[ofc_pkg::IRQ_ZERO_N_BIT] = 1'b1;
							else
							begin
								r_nxt.state = ofc_pkg::ST_ARM;
								r_nxt.meas_sel = w[ofc_pkg::CTRL_SEL_LSB +: 2];
								r_nxt.result = 32'h0000_0000;
								r_nxt.osc_left = r.ref_count;
							end
						end
					end
				end
				ofc_pkg::ADDR_IRQ_STATUS:
					w = merge(32'h0, r.wdata, r.wstrb);
				ofc_pkg::ADDR_IRQ_MASK:
					r_nxt.irq_mask = 2'(merge({30'h0, r.irq_mask}, r.wdata, r.wstrb));
				ofc_pkg::ADDR_RESULT_LOW,
				ofc_pkg::ADDR_RESULT_HIGH: ;
				default: r_nxt.bresp = ofc_pkg::RESP_SLVERR;
			endcase
		end
		if (r.bvalid && s_axi_bready)
			r_nxt.bvalid = 1'b0;
		// Write-one-to-clear; a new event in the same cycle wins
		if (wr_go && r.awaddr == ofc_pkg::ADDR_IRQ_STATUS)
			r_nxt.irq_status = (r.irq_status & ~w[1:0]) | set_ev;
		else
			r_nxt.irq_status = r.irq_status | set_ev;
		// AXI read
		if (s_axi_arvalid && !r.rvalid)
		begin
			r_nxt.rvalid = 1'b1;
			r_nxt.rresp = ofc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				ofc_pkg::ADDR_REF_COUNT: r_nxt.rdata = r.ref_count;
				ofc_pkg::ADDR_CTRL:
					r_nxt.rdata = {28'h0, busy, busy, r.sel};
				// M is stable once start reads zero, so halves need no snapshot
				ofc_pkg::ADDR_RESULT_LOW:  r_nxt.rdata = {16'h0, r.result[15:0]};
				ofc_pkg::ADDR_RESULT_HIGH: r_nxt.rdata = {16'h0, r.result[31:16]};
				ofc_pkg::ADDR_IRQ_STATUS:  r_nxt.rdata = {30'h0, r.irq_status};
				ofc_pkg::ADDR_IRQ_MASK:    r_nxt.rdata = {30'h0, r.irq_mask};
				default:
				begin
					r_nxt.rdata = 32'h0000_0000;
					r_nxt.rresp = ofc_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (r.rvalid && s_axi_rready)
			r_nxt.rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.state <= ofc_pkg::ST_IDLE;
			r.ref_count <= ofc_pkg::RESET_REF_COUNT;
			r.sel <= ofc_pkg::RESET_SEL;
			r.irq_mask <= ofc_pkg::RESET_IRQ_MASK;
		end
		else
			r <= r_nxt;
	end

	assign s_axi_awready = !r.awvalid_seen;
	assign s_axi_wready  = !r.wvalid_seen;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign irq           = |(r.irq_status & r.irq_mask);
endmodule
`default_nettype wire

// ===== bench/ofc_calibrator_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_chk
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_RST_IDLE: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("not idle after reset");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("rdata changed");
	AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answered twice");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& !s_axi_bvalid |=> ##1 s_axi_bvalid) else $error("no write answer");
	AST_UNMAPPED: assert property (s_axi_rvalid && s_axi_rresp[1] |-> s_axi_rdata == 32'h0)
		else $error("unmapped data");
	AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
		else $error("bad bresp");
endmodule
bind ofc_calibrator ofc_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  osc_clk = 4'h0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd, m;
	logic        ta, tw, tb;
	int          errors = 0;
	int          n_checks = 0;
	int          cnt = 0;
	int          k;
	int          q;
	int          hs[4] = '{6, 3, 8, 10};

	ofc_calibrator DUT (.aclk, .aresetn, .osc_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);

	always #10 aclk = ~aclk;
	// Oscillators as clock-derived squares so every period is an exact cycle count
	always @(posedge aclk)
	begin
		cnt <= cnt + 1;
		for (int i = 0; i < 4; i++)
			osc_clk[i] <= (cnt / hs[i]) % 2 == 1;
	end

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	// Reference tick is jittered, so one tick either way is accepted
	task automatic ckn(input string n, input int e, input logic [31:0] g);
		n_checks++;
		if ((g + 1 >= e && g <= e + 1) !== 1'b1)
		begin
			errors++;
			$display("ERROR %s exp %0d got %0d", n, e, g);
		end
	endtask
	task automatic tmo(input int j);
		if (j >= 200)
		begin
			errors++;
			$display("ERROR wait exp done got timeout");
			final_report();
		end
	endtask
	// Ready is raised late on purpose so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int j;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (j = 0; j < 200; j++)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid & s_axi_bready;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
			if (j > 1) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		tmo(j);
	endtask
	task automatic rdr(input logic [7:0] a);
		int j;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (j = 0; j < 200; j++)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tb = s_axi_rvalid & s_axi_rready;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tb) break;
			if (j > 0) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		tmo(j);
	endtask

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(ofc_pkg::ADDR_REF_COUNT);
		ck("ref_cycle_count", 32'h0, rd);
		rdr(ofc_pkg::ADDR_CTRL);
		ck("ctrl", 32'h0, rd);
		rdr(8'h18);
		ck("unmapped rdata", 32'h0, rd);
		ck("rresp", 32'(ofc_pkg::RESP_SLVERR), 32'(rs));
		wr(8'h18, 32'h1);
		ck("bresp", 32'(ofc_pkg::RESP_SLVERR), 32'(rs));
		$display("test reset done");
		// Last pass repeats the enhanced rc, as software does every active period
		for (int s = 0; s < 5; s++)
		begin
			q = (s > 3) ? 3 : s;
			wr(ofc_pkg::ADDR_REF_COUNT, 32'd25);
			wr(ofc_pkg::ADDR_CTRL, 32'(q) | 32'h4);
			wr(ofc_pkg::ADDR_REF_COUNT, 32'd7);
			rd = 32'h4;
			for (k = 0; k < 200 && rd[2]; k++)
				rdr(ofc_pkg::ADDR_CTRL);
			tmo(k);
			ck("ctrl", 32'(q), rd);
			rdr(ofc_pkg::ADDR_RESULT_LOW);
			m[15:0] = rd[15:0];
			rdr(ofc_pkg::ADDR_RESULT_HIGH);
			m[31:16] = rd[15:0];
			ckn("result", 16 * hs[q], m);
			rdr(ofc_pkg::ADDR_REF_COUNT);
			ck("ref_cycle_count", 32'd25, rd);
		end
		$display("test measure done");
		rdr(ofc_pkg::ADDR_IRQ_STATUS);
		ck("irq_status", 32'h1, rd);
		ck("irq", 32'h0, 32'(irq));
		wr(ofc_pkg::ADDR_IRQ_MASK, 32'h1);
		ck("irq", 32'h1, 32'(irq));
		wr(ofc_pkg::ADDR_IRQ_STATUS, 32'h1);
		ck("irq", 32'h0, 32'(irq));
		$display("test irq done");
		wr(ofc_pkg::ADDR_IRQ_MASK, 32'h3);
		wr(ofc_pkg::ADDR_REF_COUNT, 32'h0);
		wr(ofc_pkg::ADDR_CTRL, 32'h4);
		rdr(ofc_pkg::ADDR_IRQ_STATUS);
		ck("irq_status", 32'h2, rd);
		ck("irq", 32'h1, 32'(irq));
		rdr(ofc_pkg::ADDR_CTRL);
		ck("ctrl", 32'h0, rd);
		$display("test zero count done");
		s_axi_wstrb <= 4'h3;
		wr(ofc_pkg::ADDR_REF_COUNT, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'hF;
		rdr(ofc_pkg::ADDR_REF_COUNT);
		ck("ref_cycle_count", 32'h0000_FFFF, rd);
		$display("test strobe done");
		final_report();
	end
endmodule
`default_nettype wire
